/* verilog/rssf_regs.svh */
// Constants for the regulator safety status flag bank
// Function
// - Set flags hold until register is read
// - Read clears flags whose condition has gone
// - Power-on reset zeroes every status bit
// - Status registers are read-only, writes ignored
// - Thermal registers: bit1 shutdown, bit0 warning
// - Boost fault bit4 flags ground loss
// - Boost fault bit3 flags overvoltage
// - Boost fault bit2 flags sink current limit
// - Boost fault bit1 flags overload
// - Boost fault bit0 flags short to ground
// - General error bit layout, bits 7:6 reserved
// - Config CRC mismatch sets bit 5
// - EEPROM CRC mismatch sets bit 4
// - Serial error code 00/01/10/11 encoding
// - Driver read-back disagreement sets error bit
`ifndef RSSF_REGS_SVH
`define RSSF_REGS_SVH
`define RSSF_RESET_VALUE       8'h00
`define RSSF_THERM_WARN_BIT    0
`define RSSF_THERM_SHDN_BIT    1
`define RSSF_BOOST_SHORT_BIT   0
`define RSSF_BOOST_OVL_BIT     1
`define RSSF_BOOST_SINK_BIT    2
`define RSSF_BOOST_OVERV_BIT   3
`define RSSF_BOOST_GND_BIT     4
`define RSSF_ERR_SPI_LO_BIT    0
`define RSSF_ERR_SPI_HI_BIT    1
`define RSSF_ERR_ENIRQ_BIT     2
`define RSSF_ERR_RESDRV_BIT    3
`define RSSF_ERR_EECRC_BIT     4
`define RSSF_ERR_CFGCRC_BIT    5
`define RSSF_SPI_NONE          2'h0
`define RSSF_SPI_CMD           2'h1
`define RSSF_SPI_FORMAT        2'h2
`define RSSF_SPI_MISMATCH      2'h3
`endif

/* verilog/rssf_pkg.sv */
// Types for the regulator safety status flag bank
package rssf_pkg;
    typedef logic [7:0] rssf_byte_t;
    typedef enum logic [1:0] {
        RSSF_SEL_BUCK2_THERM,
        RSSF_SEL_BOOST_FAULT,
        RSSF_SEL_BOOST_THERM,
        RSSF_SEL_GENERAL_ERR
    } rssf_sel_e;
endpackage

/* verilog/rssf_flag_reg.sv */
// One read-to-clear status flag register
`timescale 1ns/1ps
`include "rssf_regs.svh"
module rssf_flag_reg (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] cond,
    input  wire logic [7:0] valid_mask,
    input  wire logic       rd_clear,
    output logic      [7:0] value
);
    // Sticky flags; clear drops only bits whose condition is gone, set wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            value <= `RSSF_RESET_VALUE;
        end else if (rd_clear) begin
            value <= cond & valid_mask;
        end else begin
            value <= (value | cond) & valid_mask;
        end
    end
endmodule

/* verilog/rssf_status_bank.sv */
// Regulator safety status flag bank with read-to-clear access
`timescale 1ns/1ps
`include "rssf_regs.svh"
module rssf_status_bank (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       second_buck_thermal_shutdown,
    input  wire logic       second_buck_thermal_warning,
    input  wire logic       boost_ground_loss,
    input  wire logic       boost_overvoltage,
    input  wire logic       boost_high_side_sink_limit,
    input  wire logic       boost_overload,
    input  wire logic       boost_short_to_ground,
    input  wire logic       boost_thermal_shutdown,
    input  wire logic       boost_thermal_warning,
    input  wire logic [7:0] config_crc_calc,
    input  wire logic [7:0] config_crc_expected,
    input  wire logic       config_crc_valid,
    input  wire logic [7:0] eeprom_crc_calc,
    input  wire logic [7:0] eeprom_crc_expected,
    input  wire logic       eeprom_crc_valid,
    input  wire logic       reset_driver_drive,
    input  wire logic       reset_driver_sense,
    input  wire logic       enable_irq_driver_drive,
    input  wire logic       enable_irq_driver_sense,
    input  wire logic       spi_error_valid,
    input  wire logic [1:0] spi_error_code,
    input  wire logic       read_buck2_thermal_status_cmd,
    input  wire logic       read_boost_fault_status_cmd,
    input  wire logic       read_boost_thermal_status_cmd,
    input  wire logic       read_general_error_status_cmd,
    output logic      [7:0] read_data,
    output logic            read_valid,
    output logic      [7:0] buck2_thermal_status,
    output logic      [7:0] boost_fault_status,
    output logic      [7:0] boost_thermal_status,
    output logic      [7:0] general_error_status
);
    // Implemented bits of each register; reserved bits always read zero
    localparam logic [7:0] THERM_MASK = 8'h03;
    localparam logic [7:0] BOOST_MASK = 8'h1f;
    localparam logic [7:0] ERR_MASK   = 8'h3f;

    // Condition images, one per register, and the read decode
    logic [7:0]           therm2_cond;
    logic [7:0]           boost1_cond;
    logic [7:0]           boost2_cond;
    logic [7:0]           err_cond;
    logic [7:0]           spi_code_bits;
    logic [3:0]           read_cmds;
    logic                 read_any;
    rssf_pkg::rssf_sel_e  read_sel;
    rssf_pkg::rssf_byte_t read_pick;

    // True when a checked CRC does not match its reference
    function automatic logic crc_bad(
        input logic [7:0] calc,
        input logic [7:0] exp_v,
        input logic       valid
    );
        crc_bad = valid && (calc != exp_v);
    endfunction

    // True when a driver's sensed level differs from the level it drives
    function automatic logic readback_bad(
        input logic drive,
        input logic sense
    );
        readback_bad = drive != sense;
    endfunction

    // Thermal register image: shutdown in bit 1, warning in bit 0, the rest zero
    function automatic rssf_pkg::rssf_byte_t therm_bits(
        input logic shutdown,
        input logic warning
    );
        therm_bits                       = 8'h00;
        therm_bits[`RSSF_THERM_SHDN_BIT] = shutdown;
        therm_bits[`RSSF_THERM_WARN_BIT] = warning;
    endfunction

    // Register addressed by a read; the lowest strobe wins if several rise together
    function automatic rssf_pkg::rssf_sel_e sel_from_cmds(
        input logic [3:0] cmds
    );
        if (cmds[0]) begin
            sel_from_cmds = rssf_pkg::RSSF_SEL_BUCK2_THERM;
        end else if (cmds[1]) begin
            sel_from_cmds = rssf_pkg::RSSF_SEL_BOOST_FAULT;
        end else if (cmds[2]) begin
            sel_from_cmds = rssf_pkg::RSSF_SEL_BOOST_THERM;
        end else begin
            sel_from_cmds = rssf_pkg::RSSF_SEL_GENERAL_ERR;
        end
    endfunction

    // Current contents of the addressed register, taken before any clear
    function automatic rssf_pkg::rssf_byte_t pick_status(
        input rssf_pkg::rssf_sel_e  sel,
        input rssf_pkg::rssf_byte_t b2t,
        input rssf_pkg::rssf_byte_t bf,
        input rssf_pkg::rssf_byte_t bt,
        input rssf_pkg::rssf_byte_t ge
    );
        case (sel)
            rssf_pkg::RSSF_SEL_BUCK2_THERM: pick_status = b2t;
            rssf_pkg::RSSF_SEL_BOOST_FAULT: pick_status = bf;
            rssf_pkg::RSSF_SEL_BOOST_THERM: pick_status = bt;
            rssf_pkg::RSSF_SEL_GENERAL_ERR: pick_status = ge;
            default:                        pick_status = 8'h00;
        endcase
    endfunction

    // Thermal conditions of the second buck stage and of the boost converter
    always_comb begin
        therm2_cond = therm_bits(second_buck_thermal_shutdown,
                                 second_buck_thermal_warning);
        boost2_cond = therm_bits(boost_thermal_shutdown,
                                 boost_thermal_warning);
    end

    // Boost converter fault conditions onto their bit positions
    always_comb begin
        boost1_cond                        = 8'h00;
        boost1_cond[`RSSF_BOOST_GND_BIT]   = boost_ground_loss;
        boost1_cond[`RSSF_BOOST_OVERV_BIT] = boost_overvoltage;
        boost1_cond[`RSSF_BOOST_SINK_BIT]  = boost_high_side_sink_limit;
        boost1_cond[`RSSF_BOOST_OVL_BIT]   = boost_overload;
        boost1_cond[`RSSF_BOOST_SHORT_BIT] = boost_short_to_ground;
    end

    // Serial error code counts only while its strobe is high; codes combine by OR
    always_comb begin
        spi_code_bits = 8'h00;
        if (spi_error_valid) begin
            spi_code_bits[`RSSF_ERR_SPI_HI_BIT:`RSSF_ERR_SPI_LO_BIT] =
                spi_error_code;
        end
    end

    // CRC checks and driver read-back on top of the serial error code
    always_comb begin
        err_cond = spi_code_bits;
        err_cond[`RSSF_ERR_CFGCRC_BIT] =
            crc_bad(config_crc_calc, config_crc_expected, config_crc_valid);
        err_cond[`RSSF_ERR_EECRC_BIT] =
            crc_bad(eeprom_crc_calc, eeprom_crc_expected, eeprom_crc_valid);
        err_cond[`RSSF_ERR_RESDRV_BIT] =
            readback_bad(reset_driver_drive, reset_driver_sense);
        err_cond[`RSSF_ERR_ENIRQ_BIT] =
            readback_bad(enable_irq_driver_drive, enable_irq_driver_sense);
    end

    // Gather the read strobes and pick the addressed register
    always_comb begin
        read_cmds[0] = read_buck2_thermal_status_cmd;
        read_cmds[1] = read_boost_fault_status_cmd;
        read_cmds[2] = read_boost_thermal_status_cmd;
        read_cmds[3] = read_general_error_status_cmd;
        read_any     = |read_cmds;
        read_sel     = sel_from_cmds(read_cmds);
        read_pick    = pick_status(read_sel, buck2_thermal_status, boost_fault_status,
                                   boost_thermal_status, general_error_status);
    end

    // The four status registers; no write path exists
    rssf_flag_reg u_buck2_therm (
        .clk        (clk),
        .rst        (rst),
        .cond       (therm2_cond),
        .valid_mask (THERM_MASK),
        .rd_clear   (read_buck2_thermal_status_cmd),
        .value      (buck2_thermal_status)
    );

    // Boost converter fault flags
    rssf_flag_reg u_boost_fault (
        .clk        (clk),
        .rst        (rst),
        .cond       (boost1_cond),
        .valid_mask (BOOST_MASK),
        .rd_clear   (read_boost_fault_status_cmd),
        .value      (boost_fault_status)
    );

    // Boost converter thermal flags
    rssf_flag_reg u_boost_therm (
        .clk        (clk),
        .rst        (rst),
        .cond       (boost2_cond),
        .valid_mask (THERM_MASK),
        .rd_clear   (read_boost_thermal_status_cmd),
        .value      (boost_thermal_status)
    );

    // General error flags: CRC, driver read-back, serial error code
    rssf_flag_reg u_general_err (
        .clk        (clk),
        .rst        (rst),
        .cond       (err_cond),
        .valid_mask (ERR_MASK),
        .rd_clear   (read_general_error_status_cmd),
        .value      (general_error_status)
    );

    // Reply strobe: one cycle after any read command
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            read_valid <= 1'b0;
        end else begin
            read_valid <= read_any;
        end
    end

    // Reply data: the pre-clear value, held until the next read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            read_data <= `RSSF_RESET_VALUE;
        end else if (read_any) begin
            read_data <= read_pick;
        end
    end
endmodule

/* tb/rssf_chk.sv */
// Assertions on the ports of the safety status flag bank
`timescale 1ns/1ps
module rssf_chk (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       boost_ground_loss,
    input wire logic       boost_overvoltage,
    input wire logic       read_boost_fault_status_cmd,
    input wire logic [7:0] read_data,
    input wire logic       read_valid,
    input wire logic [7:0] buck2_thermal_status,
    input wire logic [7:0] boost_fault_status,
    input wire logic [7:0] boost_thermal_status,
    input wire logic [7:0] general_error_status
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Reserved bits of all four registers, reset values, then latching, setting, read-clear and reply of the fault register
    a_fault_reserved: assert property (
        boost_fault_status[7:5] == 3'h0) else $error("fault reserved");
    a_therm_reserved: assert property (
        buck2_thermal_status[7:2] == 6'h00) else $error("therm reserved");
    a_err_reserved: assert property (
        general_error_status[7:6] == 2'h0) else $error("err reserved");
    a_boost_therm_rsvd: assert property (
        boost_thermal_status[7:2] == 6'h00) else $error("boost therm reserved");
    a_reset_zero: assert property ($fell(rst) |->
        boost_fault_status == 8'h00 && buck2_thermal_status == 8'h00 &&
        general_error_status == 8'h00 && boost_thermal_status == 8'h00 && !read_valid)
        else $error("reset value");
    a_fault_hold: assert property (!read_boost_fault_status_cmd |=>
        (boost_fault_status & $past(boost_fault_status)) == $past(boost_fault_status))
        else $error("flag lost");
    a_gnd_sets: assert property (
        boost_ground_loss |=> boost_fault_status[4]) else $error("gnd flag");
    a_ovp_sets: assert property (
        boost_overvoltage |=> boost_fault_status[3]) else $error("ovp flag");
    a_read_clears: assert property (
        read_boost_fault_status_cmd && !boost_overvoltage |=> !boost_fault_status[3])
        else $error("no clear");
    a_read_reply: assert property (read_boost_fault_status_cmd |=>
        read_valid && read_data == $past(boost_fault_status)) else $error("reply");
    c_fault_read: cover property (read_boost_fault_status_cmd && boost_fault_status != 8'h00);
    c_therm_set: cover property (buck2_thermal_status == 8'h03);
    c_err_set: cover property (general_error_status[5:2] == 4'hf);
endmodule
bind rssf_status_bank rssf_chk chk (
    .clk                         (clk),
    .rst                         (rst),
    .boost_ground_loss           (boost_ground_loss),
    .boost_overvoltage           (boost_overvoltage),
    .read_boost_fault_status_cmd (read_boost_fault_status_cmd),
    .read_data                   (read_data),
    .read_valid                  (read_valid),
    .buck2_thermal_status        (buck2_thermal_status),
    .boost_fault_status          (boost_fault_status),
    .boost_thermal_status        (boost_thermal_status),
    .general_error_status        (general_error_status)
);

/* tb/rssf_mcu.sv */
// Controller model that issues one-cycle read commands
`timescale 1ns/1ps
module rssf_mcu (
    input  wire logic       clk,
    output logic      [3:0] cmd
);
    initial cmd = 4'h0;
    // Read pulse only, never a write, taken at the following edge
    task automatic rd(input int s);
        @(posedge clk);
        cmd[s] <= 1'b1;
        @(posedge clk);
        cmd <= 4'h0;
    endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench for the safety status flag bank
`timescale 1ns/1ps
module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  bf = 5'h00;
    logic [3:0]  th = 4'h0;
    logic [7:0]  cc = 8'h00, ce = 8'h00, ec = 8'h00, ee = 8'h00;
    logic [5:0]  dv = 6'h00;
    logic [1:0]  sc = 2'h0;
    logic        sv = 1'b0;
    logic [3:0]  cmd;
    logic [7:0]  rdat;
    logic        rval;
    logic [31:0] r;
    logic [7:0]  q[$];
    int          fails = 0;
    int          compares = 0;
    int          seed = 32'hded3db85;
    always #5 clk = ~clk;
    rssf_mcu mcu (.clk(clk), .cmd(cmd));
    rssf_status_bank dut (.clk(clk), .rst(rst), .second_buck_thermal_shutdown(th[3]),
        .second_buck_thermal_warning(th[2]), .boost_ground_loss(bf[4]),
        .boost_overvoltage(bf[3]), .boost_high_side_sink_limit(bf[2]), .boost_overload(bf[1]),
        .boost_short_to_ground(bf[0]), .boost_thermal_shutdown(th[1]),
        .boost_thermal_warning(th[0]), .config_crc_calc(cc), .config_crc_expected(ce),
        .config_crc_valid(dv[0]), .eeprom_crc_calc(ec), .eeprom_crc_expected(ee),
        .eeprom_crc_valid(dv[1]), .reset_driver_drive(dv[2]), .reset_driver_sense(dv[3]),
        .enable_irq_driver_drive(dv[4]), .enable_irq_driver_sense(dv[5]),
        .spi_error_valid(sv), .spi_error_code(sc), .read_buck2_thermal_status_cmd(cmd[0]),
        .read_boost_fault_status_cmd(cmd[1]), .read_boost_thermal_status_cmd(cmd[2]),
        .read_general_error_status_cmd(cmd[3]), .read_data(rdat), .read_valid(rval),
        .buck2_thermal_status(), .boost_fault_status(), .boost_thermal_status(),
        .general_error_status());
    // Each reply is matched against the oldest note
    always @(posedge clk) begin
        if (rval === 1'b1) begin
            compares++;
            if (q.size() == 0 || rdat !== q[0]) begin
                fails++;
                $display("ERROR %0t read %h", $time, rdat);
            end
            if (q.size() != 0) void'(q.pop_front());
        end
    end
    task automatic rd(input int s, input logic [7:0] e);
        q.push_back(e);
        mcu.rd(s);
        @(posedge clk);
    endtask
    task automatic end_sim;
        if (fails == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Main sequence: fault pulses, held conditions, error sources
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int s = 0; s < 4; s++) rd(s, 8'h00);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk) bf <= 5'h01 << i;
            @(posedge clk) bf <= 5'h00;
            repeat (3) @(posedge clk);
            rd(1, 8'h01 << i);
            rd(1, 8'h00);
        end
        // Mid-run reset wipes latched flags
        @(posedge clk) bf <= 5'h1f;
        @(posedge clk) begin
            bf  <= 5'h00;
            rst <= 1'b1;
        end
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(1, 8'h00);
        @(posedge clk) th <= 4'hf;
        @(posedge clk) th <= 4'h4;
        rd(0, 8'h03);
        rd(2, 8'h03);
        rd(0, 8'h01);
        @(posedge clk) th <= 4'h0;
        rd(0, 8'h01);
        rd(0, 8'h00);
        fork
            rd(1, 8'h00);
            begin
                @(posedge clk) bf <= 5'h02;
                @(posedge clk) bf <= 5'h00;
            end
        join
        rd(1, 8'h02);
        for (int k = 0; k < 4; k++) begin
            r = $random(seed);
            @(posedge clk) begin
                cc <= r[7:0];
                ce <= r[7:0] ^ {7'h00, k[0]};
                ec <= r[15:8];
                ee <= r[15:8] ^ {7'h00, k[1]};
                dv <= {r[17] ^ k[1], r[17], r[16] ^ k[0], r[16], 2'h3};
                sv <= 1'b1;
                sc <= k[1:0];
            end
            @(posedge clk) {dv, sv} <= 7'h00;
            rd(3, {2'h0, k[0], k[1], k[0], k[1], k[1:0]});
            rd(3, 8'h00);
        end
        repeat (2) @(posedge clk);
        if (q.size() != 0) begin
            fails++;
            $display("ERROR %0t reply missing", $time);
        end
        end_sim;
    end
    // Watchdog against a hung run
    initial begin
        repeat (2000) @(posedge clk);
        fails++;
        end_sim;
    end
endmodule
